// ### inc/port_filter_defines.svh
// Purpose: Offsets, field positions, reset values and sizes of the port filter block.
// Assumes: APB with 32-bit data; every register is one aligned word.
// Notes: Included by the filter design, the assertion module and the bench.
`ifndef PORT_FILTER_DEFINES_SVH
`define PORT_FILTER_DEFINES_SVH

`define OFS_CFG         12'h000
`define OFS_RSTART_LO   12'h004
`define OFS_RSTART_HI   12'h008
`define OFS_REND_LO     12'h00C
`define OFS_REND_HI     12'h010
`define OFS_RMASK_LO    12'h014
`define OFS_RMASK_HI    12'h018
`define OFS_FVAL_LO     12'h01C
`define OFS_FVAL_HI     12'h020
`define OFS_FMASK_LO    12'h024
`define OFS_FMASK_HI    12'h028
`define OFS_INSERT      12'h02C
`define OFS_STATUS      12'h030

`define CFG_PORT_LSB    0
`define CFG_EXIT_BIT    4
`define CFG_PMODE_LSB   5
`define CFG_MPORT_LSB   7
`define CFG_RMODE_LSB   11
`define CFG_FMODE_LSB   13
`define CFG_ORIGIN_LSB  15
`define CFG_OFFSET_LSB  17
`define INS_CLEAR_BIT   31
`define ST_COUNT_LSB    0
`define ST_BUSY_BIT     7
`define ST_DISC_LSB     16

`define RST_MASK48      48'hFFFFFFFFFFFF
`define RST_MASK64      64'hFFFFFFFFFFFFFFFF
`define DEFAULT_INDEX   4'h1
`define NUM_FILTERS     4
`define FRAME_BYTES     512
`define FIFO_DEPTH      8
`define SA_POS          10'h006
`define MAC_HDR_END     10'h00C
`define FIELD_OCTETS    11'h008
`define LEN_MAX_8023    16'h05DC
`define LLC_SNAP_SAP    8'hAA
`define SNAP_HDR_BYTES  10'h00A
`define TYPE_BYTES      10'h002
`define ETYPE_IP        16'h0800

`endif

// ### inc/port_filter_pkg.sv
// Purpose: Types shared by the port filter design.
// Assumes: Constants come from port_filter_defines.svh.
// Notes: None.
package port_filter_pkg;
   typedef enum logic [1:0] {crit_na, crit_match, crit_nomatch, crit_rsvd} crit_mode_type;
   typedef enum logic [1:0] {
      type_origin, ip_origin, mac_origin, source_routing_origin
   } origin_type;
   typedef struct packed {
      logic [3:0] port;
      logic exit_dir;
      crit_mode_type port_mode;
      logic [3:0] match_port;
      crit_mode_type range_mode;
      logic [47:0] range_start;
      logic [47:0] range_end;
      logic [47:0] range_mask;
      crit_mode_type field_mode;
      origin_type origin;
      logic [7:0] offset;
      logic [63:0] field_value;
      logic [63:0] field_mask;
   } filter_type;
   typedef struct packed {
      logic [7:0] data;
      logic last;
      logic [3:0] in_port;
      logic [3:0] out_port;
      logic forwarded;
   } beat_type;
   typedef struct packed {
      logic discard;
      logic [3:0] hit_index;
      logic [3:0] in_port;
      logic [3:0] out_port;
   } verdict_type;
endpackage

// ### hw/port_filter_field_match.sv
// Purpose: Port filter engine for a LAN bridge: buffers a frame, evaluates the filter table,
//          and reports a discard verdict per frame.
// Assumes: Frame beats arrive synchronous to pclk; filters are staged and inserted over APB.
// Notes: One filter is evaluated per cycle after the last beat of a frame.
`timescale 1ns/1ps
`include "port_filter_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module beat_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [WIDTH-1:0] rd_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [AW:0] fill_q;
   logic push;
   logic pop;

   assign wr_ready = (fill_q != DEPTH[AW:0]);
   assign rd_valid = (fill_q != '0);
   assign push = wr_valid && wr_ready && ce;
   assign pop = rd_valid && rd_ready && ce;
   assign rd_data = mem[rd_ptr_q];

   always_ff @(posedge pclk) begin
      if (push) begin
         mem[wr_ptr_q] <= wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         fill_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            fill_q <= fill_q + 1'b1;
         end else if (pop && !push) begin
            fill_q <= fill_q - 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module port_filter_field_match (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic in_valid,
   output logic in_ready,
   input wire port_filter_pkg::beat_type in_beat,
   output logic verdict_valid,
   input wire logic verdict_ready,
   output port_filter_pkg::verdict_type verdict
);
   import port_filter_pkg::*;

   typedef enum logic [1:0] {st_collect, st_eval, st_report} state_type;
   localparam int NF = `NUM_FILTERS;
   localparam int BW = $bits(beat_type);

   state_type state_q;
   filter_type stage_q;
   filter_type table_q [NF];
   logic [3:0] count_q;
   logic [15:0] disc_cnt_q;
   logic [31:0] prdata_q;
   logic [7:0] frame_mem [`FRAME_BYTES];
   logic [9:0] len_q;
   logic [3:0] in_port_q;
   logic [3:0] out_port_q;
   logic fwd_q;
   logic [3:0] fi_q;
   logic hit_q;
   logic [3:0] hit_idx_q;
   verdict_type verdict_q;

   logic fifo_valid;
   logic [BW-1:0] fifo_data;
   beat_type beat;
   logic take;

   ////////////////////////////////////////////////////////////////////////////
   // Input buffering: back-pressure reaches the source while a frame is judged
   beat_fifo #(.WIDTH(BW), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .wr_valid(in_valid),
      .wr_ready(in_ready),
      .wr_data(in_beat),
      .rd_valid(fifo_valid),
      .rd_ready(state_q == st_collect),
      .rd_data(fifo_data)
   );
   assign beat = beat_type'(fifo_data);
   assign take = ce && fifo_valid && (state_q == st_collect);

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, read data latched in the setup cycle
   logic setup;
   logic wr_acc;
   logic mapped;
   logic [3:0] ins_idx;
   logic ins_clear;
   logic ins_ok;
   logic [31:0] rd_mux;

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite && ce;
   assign mapped = (paddr <= `OFS_STATUS) && (paddr[1:0] == 2'b00);
   assign ins_clear = pwdata[`INS_CLEAR_BIT];
   assign ins_idx = (pwdata[3:0] == 4'h0) ? `DEFAULT_INDEX : pwdata[3:0];
   // Index must land inside the filled table plus one; no inserts mid-evaluation
   assign ins_ok = ins_clear || ((ins_idx <= count_q + 4'h1) && (count_q < 4'(NF))
                   && (state_q != st_eval));
   assign pready = 1'b1;
   assign pslverr = psel && penable && (!mapped || (pwrite && paddr == `OFS_INSERT && !ins_ok));
   assign prdata = prdata_q;

   always_comb begin
      rd_mux = 32'h0;
      case (paddr)
         `OFS_CFG: begin
            rd_mux[`CFG_PORT_LSB +: 4] = stage_q.port;
            rd_mux[`CFG_EXIT_BIT] = stage_q.exit_dir;
            rd_mux[`CFG_PMODE_LSB +: 2] = stage_q.port_mode;
            rd_mux[`CFG_MPORT_LSB +: 4] = stage_q.match_port;
            rd_mux[`CFG_RMODE_LSB +: 2] = stage_q.range_mode;
            rd_mux[`CFG_FMODE_LSB +: 2] = stage_q.field_mode;
            rd_mux[`CFG_ORIGIN_LSB +: 2] = stage_q.origin;
            rd_mux[`CFG_OFFSET_LSB +: 8] = stage_q.offset;
         end
         `OFS_RSTART_LO: rd_mux = stage_q.range_start[31:0];
         `OFS_RSTART_HI: rd_mux[15:0] = stage_q.range_start[47:32];
         `OFS_REND_LO: rd_mux = stage_q.range_end[31:0];
         `OFS_REND_HI: rd_mux[15:0] = stage_q.range_end[47:32];
         `OFS_RMASK_LO: rd_mux = stage_q.range_mask[31:0];
         `OFS_RMASK_HI: rd_mux[15:0] = stage_q.range_mask[47:32];
         `OFS_FVAL_LO: rd_mux = stage_q.field_value[31:0];
         `OFS_FVAL_HI: rd_mux = stage_q.field_value[63:32];
         `OFS_FMASK_LO: rd_mux = stage_q.field_mask[31:0];
         `OFS_FMASK_HI: rd_mux = stage_q.field_mask[63:32];
         `OFS_STATUS: begin
            rd_mux[`ST_COUNT_LSB +: 4] = count_q;
            rd_mux[`ST_BUSY_BIT] = (state_q != st_collect);
            rd_mux[`ST_DISC_LSB +: 16] = disc_cnt_q;
         end
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
      end else if (ce && setup && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end

   // Staging filter; a write to the insert register copies it into the table
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_q <= '0;
         stage_q.origin <= type_origin;
         stage_q.range_mask <= `RST_MASK48;
         stage_q.field_mask <= `RST_MASK64;
      end else if (wr_acc) begin
         case (paddr)
            `OFS_CFG: begin
               stage_q.port <= pwdata[`CFG_PORT_LSB +: 4];
               stage_q.exit_dir <= pwdata[`CFG_EXIT_BIT];
               stage_q.port_mode <= crit_mode_type'(pwdata[`CFG_PMODE_LSB +: 2]);
               stage_q.match_port <= pwdata[`CFG_MPORT_LSB +: 4];
               stage_q.range_mode <= crit_mode_type'(pwdata[`CFG_RMODE_LSB +: 2]);
               stage_q.field_mode <= crit_mode_type'(pwdata[`CFG_FMODE_LSB +: 2]);
               stage_q.origin <= origin_type'(pwdata[`CFG_ORIGIN_LSB +: 2]);
               stage_q.offset <= pwdata[`CFG_OFFSET_LSB +: 8];
            end
            // Both range ends are kept separately; equal ends match one address
            `OFS_RSTART_LO: stage_q.range_start[31:0] <= pwdata;
            `OFS_RSTART_HI: stage_q.range_start[47:32] <= pwdata[15:0];
            `OFS_REND_LO: stage_q.range_end[31:0] <= pwdata;
            `OFS_REND_HI: stage_q.range_end[47:32] <= pwdata[15:0];
            `OFS_RMASK_LO: stage_q.range_mask[31:0] <= pwdata;
            `OFS_RMASK_HI: stage_q.range_mask[47:32] <= pwdata[15:0];
            `OFS_FVAL_LO: stage_q.field_value[31:0] <= pwdata;
            `OFS_FVAL_HI: stage_q.field_value[63:32] <= pwdata;
            `OFS_FMASK_LO: stage_q.field_mask[31:0] <= pwdata;
            `OFS_FMASK_HI: stage_q.field_mask[63:32] <= pwdata;
            default: ;
         endcase
      end
   end

   // One table for all ports; inserting pushes later filters up by one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= 4'h0;
         for (int i = 0; i < NF; i++) begin
            table_q[i] <= '0;
         end
      end else if (wr_acc && paddr == `OFS_INSERT && ins_ok) begin
         if (ins_clear) begin
            count_q <= 4'h0;
         end else begin
            count_q <= count_q + 4'h1;
            for (int i = 0; i < NF; i++) begin
               if (i == int'(ins_idx) - 1) begin
                  table_q[i] <= stage_q;
               end else if (i > int'(ins_idx) - 1) begin
                  table_q[i] <= table_q[i - 1];
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame capture
   always_ff @(posedge pclk) begin
      if (take && len_q < 10'(`FRAME_BYTES)) begin
         frame_mem[len_q[8:0]] <= beat.data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         len_q <= 10'h0;
         in_port_q <= 4'h0;
         out_port_q <= 4'h0;
         fwd_q <= 1'b0;
      end else if (take) begin
         // Bytes past the buffer are dropped; the length saturates with them
         if (len_q < 10'(`FRAME_BYTES)) begin
            len_q <= len_q + 10'h1;
         end
         if (beat.last) begin
            in_port_q <= beat.in_port;
            out_port_q <= beat.out_port;
            fwd_q <= beat.forwarded;
         end
      end else if (ce && state_q == st_report && verdict_ready) begin
         len_q <= 10'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Header parsing for the field origins
   function automatic logic [7:0] octet(input logic [9:0] pos);
      return frame_mem[pos[8:0]];
   endfunction

   logic rif_present;
   logic [9:0] sr_end;
   logic [15:0] len_type;
   logic snap;
   logic [9:0] type_end;
   logic [15:0] ether_type;
   logic [9:0] ip_end;
   logic [47:0] src_addr;

   always_comb begin
      // Routing indicator is the group bit of the source address
      rif_present = frame_mem[9'(`SA_POS)][0];
      sr_end = `MAC_HDR_END
               + (rif_present ? {5'h0, frame_mem[9'(`MAC_HDR_END)][4:0]} : 10'h0);
      len_type = {octet(sr_end), octet(sr_end + 10'h1)};
      snap = (len_type <= `LEN_MAX_8023) && (octet(sr_end + 10'h2) == `LLC_SNAP_SAP)
             && (octet(sr_end + 10'h3) == `LLC_SNAP_SAP);
      // SNAP frames carry the real type eight bytes later; the origin follows it
      type_end = sr_end + (snap ? `SNAP_HDR_BYTES : `TYPE_BYTES);
      ether_type = snap ? {octet(type_end - 10'h2), octet(type_end - 10'h1)} : len_type;
      ip_end = type_end + {4'h0, frame_mem[type_end[8:0]][3:0], 2'b00};
      for (int k = 0; k < 6; k++) begin
         src_addr[47 - 8 * k -: 8] = octet(`SA_POS + 10'(k));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Evaluation of the filter under the index counter
   filter_type cur;
   logic [9:0] origin_pos;
   logic origin_ok;
   logic [10:0] field_start;
   logic field_fits;
   logic [63:0] field_got;
   logic field_hit;
   logic range_hit;
   logic port_hit;
   logic applies;
   logic any_m;
   logic all_m;
   logic any_n;
   logic all_n;
   logic fires;

   always_comb begin
      cur = table_q[fi_q[1:0]];
      origin_ok = 1'b1;
      case (cur.origin)
         type_origin: origin_pos = type_end;
         ip_origin: begin
            origin_pos = ip_end;
            origin_ok = (ether_type == `ETYPE_IP);
         end
         mac_origin: origin_pos = 10'h0;
         source_routing_origin: origin_pos = sr_end;
         default: origin_pos = type_end;
      endcase
      field_start = {1'b0, origin_pos} + {3'h0, cur.offset};
      // Never compare bytes that the frame did not deliver
      field_fits = (field_start + `FIELD_OCTETS) <= {1'b0, len_q};
      for (int k = 0; k < 8; k++) begin
         field_got[63 - 8 * k -: 8] = octet(field_start[9:0] + 10'(k));
      end
      field_hit = origin_ok && field_fits
                  && ((field_got & cur.field_mask) == (cur.field_value & cur.field_mask));
      range_hit = ((src_addr & cur.range_mask) >= (cur.range_start & cur.range_mask))
                  && ((src_addr & cur.range_mask) <= (cur.range_end & cur.range_mask));
      port_hit = (cur.match_port == in_port_q);
      applies = cur.exit_dir ? (cur.port == out_port_q) : (cur.port == in_port_q);
      any_m = 1'b0;
      all_m = 1'b1;
      any_n = 1'b0;
      all_n = 1'b1;
      // The source port criterion only means something on an exit filter
      if (cur.exit_dir && cur.port_mode == crit_match) begin
         any_m = 1'b1;
         all_m = all_m && port_hit;
      end
      if (cur.exit_dir && cur.port_mode == crit_nomatch) begin
         any_n = 1'b1;
         all_n = all_n && port_hit;
      end
      if (cur.range_mode == crit_match) begin
         any_m = 1'b1;
         all_m = all_m && range_hit;
      end
      if (cur.range_mode == crit_nomatch) begin
         any_n = 1'b1;
         all_n = all_n && range_hit;
      end
      if (cur.field_mode == crit_match) begin
         any_m = 1'b1;
         all_m = all_m && field_hit;
      end
      if (cur.field_mode == crit_nomatch) begin
         any_n = 1'b1;
         all_n = all_n && field_hit;
      end
      // Match flags must all hold; no-match flags fire unless all hold
      fires = applies && (any_m || any_n) && (!any_m || all_m)
              && (!any_n || !all_n);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= st_collect;
         fi_q <= 4'h0;
         hit_q <= 1'b0;
         hit_idx_q <= 4'h0;
      end else if (ce) begin
         case (state_q)
            st_collect: begin
               if (take && beat.last) begin
                  state_q <= st_eval;
                  fi_q <= 4'h0;
                  hit_q <= 1'b0;
               end
            end
            st_eval: begin
               // Local traffic skips the table and is always passed
               if (!fwd_q || fi_q >= count_q) begin
                  state_q <= st_report;
               end else begin
                  if (fires && !hit_q) begin
                     hit_q <= 1'b1;
                     hit_idx_q <= fi_q + 4'h1;
                  end
                  fi_q <= fi_q + 4'h1;
               end
            end
            st_report: begin
               if (verdict_ready) begin
                  state_q <= st_collect;
               end
            end
            default: state_q <= st_collect;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         verdict_q <= '0;
         disc_cnt_q <= 16'h0;
      end else if (ce && state_q == st_eval && (!fwd_q || fi_q >= count_q)) begin
         verdict_q.discard <= fwd_q && hit_q;
         verdict_q.hit_index <= fwd_q && hit_q ? hit_idx_q : 4'h0;
         verdict_q.in_port <= in_port_q;
         verdict_q.out_port <= out_port_q;
         if (fwd_q && hit_q) begin
            disc_cnt_q <= disc_cnt_q + 16'h1;
         end
      end
   end

   assign verdict_valid = (state_q == st_report);
   assign verdict = verdict_q;
endmodule

// ### verif/port_filter_field_match_asserts.sv
// Purpose: Port-level checks of the filter engine
// Assumes: Zero-wait APB, verdict held until taken
// Notes: Sees the top ports only
`timescale 1ns/1ps
`include "port_filter_defines.svh"
module port_filter_field_match_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire port_filter_pkg::beat_type in_beat,
   input wire logic verdict_valid,
   input wire logic verdict_ready,
   input wire port_filter_pkg::verdict_type verdict
);
   import port_filter_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence access_s;
      psel && penable;
   endsequence
   sequence bad_addr_s;
      access_s ##0 (paddr > `OFS_STATUS);
   endsequence
   sequence waiting_s;
      verdict_valid && !verdict_ready;
   endsequence
   zero_wait_a: assert property (access_s |-> pready)
      else $error("pready low in access");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   unmapped_err_a: assert property (bad_addr_s |-> pslverr)
      else $error("unmapped access not refused");
   unmapped_zero_a: assert property (psel && !penable && !pwrite && ce
      && paddr > `OFS_STATUS |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   verdict_hold_a: assert property (waiting_s |=> verdict_valid && $stable(verdict))
      else $error("verdict dropped early");
   verdict_once_a: assert property (verdict_valid && verdict_ready && ce |=> !verdict_valid)
      else $error("verdict repeated");
   hit_range_a: assert property (verdict_valid && verdict.discard |->
      verdict.hit_index != 4'h0 && verdict.hit_index <= `NUM_FILTERS)
      else $error("bad hit index");
   no_hit_a: assert property (verdict_valid && !verdict.discard |->
      verdict.hit_index == 4'h0)
      else $error("hit index on pass");
   freeze_a: assert property (!ce |=> $stable(verdict_valid) && $stable(verdict))
      else $error("state moved with ce low");
endmodule
bind port_filter_field_match port_filter_field_match_asserts i_chk (.pclk, .presetn, .ce,
   .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .in_valid,
   .in_ready, .in_beat, .verdict_valid, .verdict_ready, .verdict);

// ### verif/lan_segment.sv
// Purpose: Segment model: sends frame beats, takes verdicts
// Assumes: Tasks are called just after a rising edge
// Notes: Idle data shows the inverse of the last beat
`timescale 1ns/1ps
module lan_segment (
   input wire logic pclk,
   input wire logic in_ready,
   output logic in_valid,
   output port_filter_pkg::beat_type in_beat,
   input wire logic verdict_valid,
   output logic verdict_ready,
   input wire port_filter_pkg::verdict_type verdict
);
   import port_filter_pkg::*;
   logic [7:0] frm [0:63];
   verdict_type got;
   initial begin
      in_valid = 1'b0;
      in_beat = '0;
      verdict_ready = 1'b0;
   end
   task automatic send(input int n, input logic fwd);
      for (int i = 0; i < n; i++) begin
         in_valid <= 1'b1;
         in_beat <= '{frm[i], i == n - 1, 4'h0, 4'h2, fwd};
         do @(posedge pclk); while (in_ready !== 1'b1);
      end
      in_valid <= 1'b0;
      in_beat <= ~in_beat;
   endtask
   task automatic take(input int stall);
      repeat (stall) @(posedge pclk);
      verdict_ready <= 1'b1;
      do @(posedge pclk); while (verdict_valid !== 1'b1);
      got = verdict;
      verdict_ready <= 1'b0;
      // Let an edge pass so a following call never re-raises ready in this step
      @(posedge pclk);
   endtask
endmodule

// ### verif/port_filter_field_match_tb.sv
// Purpose: Self-checking bench of the filter engine
// Assumes: Frame bytes count from the first destination byte
// Notes: Config, field value and low field mask staging is written before each insert; range staging once
`timescale 1ns/1ps
`include "port_filter_defines.svh"
`define CHK(a, b) begin \
   checks++; \
   if ((a) !== (b)) begin \
      n_fail++; \
      $display("[FAIL] %0t got %h want %h", $time, (a), (b)); \
   end \
end
module port_filter_field_match_tb;
   import port_filter_pkg::*;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic in_valid, in_ready, verdict_valid, verdict_ready;
   beat_type in_beat;
   verdict_type verdict;
   int n_fail, checks, cyc;
   int st [4] = '{14, 34, 0, 12};
   port_filter_field_match i_dut (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_beat, .verdict_valid,
      .verdict_ready, .verdict);
   lan_segment seg (.pclk, .in_ready, .in_valid, .in_beat, .verdict_valid, .verdict_ready,
      .verdict);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic put(input logic [31:0] cfg, input logic [63:0] v, input logic [31:0] m,
      input logic [3:0] idx);
      apb(1'b1, `OFS_CFG, cfg);
      apb(1'b1, `OFS_FVAL_HI, v[63:32]);
      apb(1'b1, `OFS_FVAL_LO, v[31:0]);
      apb(1'b1, `OFS_FMASK_LO, m);
      apb(1'b1, `OFS_INSERT, {28'h0, idx});
   endtask
   task automatic frame(input int n, input logic fwd, input logic dis, input logic [3:0] hit);
      fork
         seg.send(n, fwd);
         seg.take(n % 4);
      join
      `CHK(seg.got.discard, dis)
      `CHK(seg.got.hit_index, hit)
   endtask
   function automatic logic [63:0] ext(input int s);
      for (int i = 0; i < 8; i++) ext = {ext[55:0], seg.frm[s + i]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop;
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      ce = 1'b1;
      for (int i = 0; i < 64; i++) seg.frm[i] = i[7:0];
      // IPv4 type, header of five words
      seg.frm[12] = 8'h08;
      seg.frm[13] = 8'h00;
      seg.frm[14] = 8'h45;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      ce <= 1'b0;
      repeat (3) @(posedge pclk);
      ce <= 1'b1;
      apb(1'b0, `OFS_CFG, 0);
      `CHK(rd, 32'h0)
      apb(1'b0, `OFS_RMASK_LO, 0);
      `CHK(rd, 32'hFFFFFFFF)
      apb(1'b0, 12'h040, 0);
      `CHK(err, 1'b1)
      for (int o = 0; o < 4; o++) begin
         apb(1'b1, `OFS_INSERT, 32'h80000000);
         put({7'h0, 8'd3, o[1:0], 2'd1, 13'h0}, ext(st[o] + 3), 32'hFFFFFFFF, 4'h1);
         frame(64, 1'b1, 1'b1, 4'h1);
      end
      apb(1'b1, `OFS_INSERT, 32'h80000000);
      put({15'h0, 2'd2, 2'd1, 13'h0}, ext(0) ^ 64'hFF, 32'hFFFFFF00, 4'h1);
      frame(64, 1'b1, 1'b1, 4'h1);
      frame(7, 1'b1, 1'b0, 4'h0);
      frame(64, 1'b0, 1'b0, 4'h0);
      put(32'h0, 64'h0, 32'hFFFFFFFF, 4'h0);
      frame(64, 1'b1, 1'b1, 4'h2);
      apb(1'b0, `OFS_STATUS, 0);
      `CHK(rd[3:0], 4'h2)
      // Exit filter toward port 2 that judges the entry port of the frame
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, `OFS_INSERT, 32'h80000000);
         put({21'h0, 3'h0, p[0], 2'd1, 1'b1, 4'h2}, 64'h0, 32'hFFFFFFFF, 4'h1);
         frame(64, 1'b1, p == 0, {3'h0, p == 0});
      end
      // Single source address: same value as range start and end
      for (int a = 0; a < 4; a++) apb(1'b1, 12'(`OFS_RSTART_LO + 4 * a),
         a[0] ? 32'h0607 : 32'h08090A0B);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, `OFS_INSERT, 32'h80000000);
         put({15'h0, 2'd2, 2'd1, 2'd1, 11'h0}, ext(0) ^ k, 32'hFFFFFFFF, 4'h1);
         frame(64, 1'b1, k == 0, {3'h0, k == 0});
         apb(1'b1, `OFS_INSERT, 32'h80000000);
         put({15'h0, 2'd2, 2'd2, 2'd2, 11'h0}, ext(0) ^ k, 32'hFFFFFFFF, 4'h1);
         frame(64, 1'b1, k == 1, {3'h0, k == 1});
      end
      report_and_stop;
   end
endmodule
